// >>> hw/skip_table_xor_pkg.sv
// package: opcodes, widths and reset values for the skip/table/xor execution block
package skip_table_xor_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DATA_W      = 8;
  localparam int ROM_ADDR_W  = 12;
  localparam int ROM_DATA_W  = 15;
  localparam int RAM_ADDR_W  = 8;
  localparam int LATCH_W     = ROM_DATA_W - DATA_W;
  localparam int PAGE_W      = ROM_ADDR_W - DATA_W;

  // ****************************************************************
  // reset values and page constant
  // ****************************************************************
  localparam logic [DATA_W-1:0]  WREG_RST  = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
  localparam logic [PAGE_W-1:0]  LAST_PAGE = 4'hF;

  // ****************************************************************
  // operations executed by this block
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_NIBX      = 4'h1,
    OP_SKIPNULL  = 4'h2,
    OP_COPYSKIP  = 4'h3,
    OP_BITSKIP   = 4'h4,
    OP_TBL_CUR   = 4'h5,
    OP_TBL_LAST  = 4'h6,
    OP_XOR_REG   = 4'h7,
    OP_XOR_MEM   = 4'h8,
    OP_XOR_IMM   = 4'h9
  } op_e;

  // one-hot execution states
  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_TABLE = 3'b010,
    ST_DUMMY = 3'b100
  } state_e;
endpackage

// >>> hw/xor_null_unit.sv
// file: combinational xor with null-result detect
`timescale 1ns/1ps
module xor_null_unit (
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  output logic      [7:0] result,
  output logic            isNull
);
  always_comb begin
    result = opA ^ opB;
    isNull = (result == 8'h00);
  end
endmodule // xor_null_unit

// >>> hw/skip_table_xor_exec.sv
// file: execution logic for nibble exchange, null skips, table reads and xor
`timescale 1ns/1ps
// Overview of operation
// - nibble exchange puts memory high nibble low in register, low nibble high
// - skip_if_null drops prefetched instruction, dummy cycle when byte is zero
// - copy_and_skip_if_null loads register; zero byte also discards prefetch
// - bit-test skip discards prefetch and adds dummy cycle when bit clear
// - current-page table read: low byte to memory, high part to latch
// - last-page table read: same, but fetched from the final page
// - xor with register destination; only null flag changes
// - xor_into_memory writes result to memory byte; only null flag changes
// - immediate xor into working register; only null flag changes
module skip_table_xor_exec (
  input  wire logic                                        clk_sys,
  input  wire logic                                        rstn,
  input  wire skip_table_xor_pkg::op_e                     opValid,
  input  wire logic                                        opStart,
  input  wire logic [skip_table_xor_pkg::RAM_ADDR_W-1:0]   memAddr,
  input  wire logic [2:0]                                  bitSel,
  input  wire logic [7:0]                                  literal,
  input  wire logic [7:0]                                  memRdata,
  input  wire logic [7:0]                                  table_pointer,
  input  wire logic [skip_table_xor_pkg::PAGE_W-1:0]       curPage,
  input  wire logic [skip_table_xor_pkg::ROM_DATA_W-1:0]   romData,
  output logic                                             busy,
  output logic                                             discardPrefetch,
  output logic                                             memWe,
  output logic      [skip_table_xor_pkg::RAM_ADDR_W-1:0]   memWaddr,
  output logic      [7:0]                                  memWdata,
  output logic                                             romRe,
  output logic      [skip_table_xor_pkg::ROM_ADDR_W-1:0]   romAddr,
  output logic      [7:0]                                  working_register,
  output logic      [skip_table_xor_pkg::LATCH_W-1:0]      table_high_latch,
  output logic                                             nullFlag
);
  // ****************************************************************
  // state
  // ****************************************************************
  skip_table_xor_pkg::state_e                   state;
  skip_table_xor_pkg::state_e                   next_state;
  logic [7:0]                                   next_working_register;
  logic [skip_table_xor_pkg::LATCH_W-1:0]       next_table_high_latch;
  logic                                         next_nullFlag;
  logic                                         next_memWe;
  logic [skip_table_xor_pkg::RAM_ADDR_W-1:0]    next_memWaddr;
  logic [7:0]                                   next_memWdata;
  logic [skip_table_xor_pkg::ROM_ADDR_W-1:0]    next_romAddr;
  logic [skip_table_xor_pkg::ROM_ADDR_W-1:0]    romAddrHold;
  // table destination is captured at start, the byte lands two cycles later
  logic [skip_table_xor_pkg::RAM_ADDR_W-1:0]    tableDest;
  logic [skip_table_xor_pkg::RAM_ADDR_W-1:0]    next_tableDest;
  logic [7:0]                                   xorB;
  logic [7:0]                                   xorRes;
  logic                                         xorNull;
  logic                                         skipTaken;
  logic                                         startOk;
  logic                                         tableStart;
  logic                                         byteNull;
  logic [7:0]                                   romLow;
  logic [skip_table_xor_pkg::LATCH_W-1:0]       romHigh;

  // ****************************************************************
  // xor datapath
  // ****************************************************************
  // immediate xor takes the literal, every other form the addressed byte
  assign xorB = (opValid == skip_table_xor_pkg::OP_XOR_IMM) ? literal : memRdata;

  xor_null_unit xor_null_unit_i (
    .opA    (working_register),
    .opB    (xorB),
    .result (xorRes),
    .isNull (xorNull)
  );

  // ****************************************************************
  // start and operand decode
  // ****************************************************************
  // a start outside the execute state is refused, busy tells fetch why
  assign startOk    = opStart && (state == skip_table_xor_pkg::ST_EXEC);
  assign tableStart = startOk && (opValid == skip_table_xor_pkg::OP_TBL_CUR ||
                                  opValid == skip_table_xor_pkg::OP_TBL_LAST);
  assign byteNull   = (memRdata == 8'h00);
  // word splits at the byte boundary: low byte to memory, rest to latch
  assign romLow     = romData[skip_table_xor_pkg::DATA_W-1:0];
  assign romHigh    = romData[skip_table_xor_pkg::ROM_DATA_W-1:skip_table_xor_pkg::DATA_W];

  // ****************************************************************
  // skip decision
  // ****************************************************************
  always_comb begin
    skipTaken = 1'b0;
    if (startOk) begin
      case (opValid)
        skip_table_xor_pkg::OP_SKIPNULL: skipTaken = byteNull;
        skip_table_xor_pkg::OP_COPYSKIP: skipTaken = byteNull;
        // only the selected bit matters, a clear bit skips
        skip_table_xor_pkg::OP_BITSKIP:  skipTaken = ~memRdata[bitSel];
        default:                         skipTaken = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // fetch handshake
  // ****************************************************************
  // handshake outputs are combinational so fetch can react this cycle
  assign discardPrefetch = skipTaken;
  assign busy            = (state != skip_table_xor_pkg::ST_EXEC) ||
                           skipTaken ||
                           tableStart;
  assign romRe           = (state == skip_table_xor_pkg::ST_TABLE);
  // address comes from a flop so the rom sees a steady word address
  assign romAddr         = romAddrHold;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    // defaults hold every register; the memory write strobe drops
    next_state            = state;
    next_working_register = working_register;
    next_table_high_latch = table_high_latch;
    next_nullFlag         = nullFlag;
    next_memWe            = 1'b0;
    next_memWaddr         = memWaddr;
    next_memWdata         = memWdata;
    next_romAddr          = romAddrHold;
    next_tableDest        = tableDest;
    case (state)
      skip_table_xor_pkg::ST_EXEC: begin
        if (opStart) begin
          case (opValid)
            skip_table_xor_pkg::OP_NIBX: begin
              // memory byte and flags are left alone
              next_working_register = {memRdata[3:0], memRdata[7:4]};
            end
            skip_table_xor_pkg::OP_SKIPNULL: begin
              if (skipTaken) next_state = skip_table_xor_pkg::ST_DUMMY;
            end
            skip_table_xor_pkg::OP_COPYSKIP: begin
              next_working_register = memRdata;
              if (skipTaken) next_state = skip_table_xor_pkg::ST_DUMMY;
            end
            skip_table_xor_pkg::OP_BITSKIP: begin
              if (skipTaken) next_state = skip_table_xor_pkg::ST_DUMMY;
            end
            skip_table_xor_pkg::OP_TBL_CUR: begin
              // memAddr may move on, so the destination is captured here
              next_romAddr   = {curPage, table_pointer};
              next_tableDest = memAddr;
              next_state     = skip_table_xor_pkg::ST_TABLE;
            end
            skip_table_xor_pkg::OP_TBL_LAST: begin
              next_romAddr   = {skip_table_xor_pkg::LAST_PAGE, table_pointer};
              next_tableDest = memAddr;
              next_state     = skip_table_xor_pkg::ST_TABLE;
            end
            skip_table_xor_pkg::OP_XOR_REG: begin
              next_working_register = xorRes;
              next_nullFlag         = xorNull;
            end
            skip_table_xor_pkg::OP_XOR_MEM: begin
              // working register keeps its value, only byte and flag move
              next_memWe    = 1'b1;
              next_memWaddr = memAddr;
              next_memWdata = xorRes;
              next_nullFlag = xorNull;
            end
            skip_table_xor_pkg::OP_XOR_IMM: begin
              next_working_register = xorRes;
              next_nullFlag         = xorNull;
            end
            default: begin
            end
          endcase
        end
      end
      skip_table_xor_pkg::ST_TABLE: begin
        // word is returned by rom in the cycle the read strobe is high
        next_memWe            = 1'b1;
        next_memWaddr         = tableDest;
        next_memWdata         = romLow;
        next_table_high_latch = romHigh;
        next_state            = skip_table_xor_pkg::ST_EXEC;
      end
      skip_table_xor_pkg::ST_DUMMY: begin
        // dummy cycle replaces the discarded fetch
        next_state = skip_table_xor_pkg::ST_EXEC;
      end
      default: begin
        next_state = skip_table_xor_pkg::ST_EXEC;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset is synchronous: rstn only counts at a clock edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state            <= skip_table_xor_pkg::ST_EXEC;
      working_register <= skip_table_xor_pkg::WREG_RST;
      table_high_latch <= skip_table_xor_pkg::LATCH_RST;
      nullFlag         <= 1'b0;
      memWe            <= 1'b0;
      memWaddr         <= '0;
      memWdata         <= 8'h00;
      romAddrHold      <= '0;
      tableDest        <= '0;
    end else begin
      state            <= next_state;
      working_register <= next_working_register;
      table_high_latch <= next_table_high_latch;
      nullFlag         <= next_nullFlag;
      memWe            <= next_memWe;
      memWaddr         <= next_memWaddr;
      memWdata         <= next_memWdata;
      romAddrHold      <= next_romAddr;
      tableDest        <= next_tableDest;
    end
  end
endmodule // skip_table_xor_exec

// >>> bench/skip_table_xor_chk.sv
// checker: port relations of the skip/table/xor execution block
`timescale 1ns/1ps
module skip_table_xor_chk (
  input wire logic clk_sys, rstn, opStart, busy, discardPrefetch, memWe, romRe, nullFlag,
  input wire skip_table_xor_pkg::op_e opValid,
  input wire logic [2:0] bitSel,
  input wire logic [3:0] curPage,
  input wire logic [7:0] memAddr, memRdata, table_pointer, memWaddr, memWdata, working_register,
  input wire logic [7:0] literal,
  input wire logic [6:0] table_high_latch,
  input wire logic [11:0] romAddr,
  input wire logic [14:0] romData
);
  // busy in a start cycle means one refused cycle follows
  logic held;
  logic next_held;
  logic go;
  logic [15:0] hit;
  assign go = opStart && !held;
  assign hit = go ? 16'h0001 << opValid : 16'h0000;
  always_comb next_held = rstn && go && busy;
  always_ff @(posedge clk_sys) held <= next_held;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_nib; hit[skip_table_xor_pkg::OP_NIBX] |=> !memWe && $stable(nullFlag)
    && working_register == {$past(memRdata[3:0]), $past(memRdata[7:4])}; endproperty
  a_nib: assert property (p_nib) else $error("nibble exchange wrong");
  property p_skn; hit[skip_table_xor_pkg::OP_SKIPNULL]
    |-> discardPrefetch == (memRdata == 8'h00) && busy == discardPrefetch
    ##1 (!$past(discardPrefetch) || busy); endproperty
  a_skn: assert property (p_skn) else $error("null skip wrong");
  property p_cps; hit[skip_table_xor_pkg::OP_COPYSKIP] |-> discardPrefetch == (memRdata == 8'h00)
    ##1 working_register == $past(memRdata); endproperty
  a_cps: assert property (p_cps) else $error("copy skip wrong");
  property p_bts; hit[skip_table_xor_pkg::OP_BITSKIP]
    |-> discardPrefetch == !memRdata[bitSel]; endproperty
  a_bts: assert property (p_bts) else $error("bit skip wrong");
  property p_tcur; hit[skip_table_xor_pkg::OP_TBL_CUR] |=> romRe && romAddr == {$past(curPage),
    $past(table_pointer)} ##1 memWe && memWaddr == $past(memAddr, 2)
    && memWdata == $past(romData[7:0]) && table_high_latch == $past(romData[14:8]); endproperty
  a_tcur: assert property (p_tcur) else $error("current page table read wrong");
  property p_tlst; hit[skip_table_xor_pkg::OP_TBL_LAST] |=> romRe && romAddr ==
    {skip_table_xor_pkg::LAST_PAGE, $past(table_pointer)} ##1 memWe
    && memWdata == $past(romData[7:0]) && table_high_latch == $past(romData[14:8]); endproperty
  a_tlst: assert property (p_tlst) else $error("last page table read wrong");
  property p_xrg; hit[skip_table_xor_pkg::OP_XOR_REG] |=> !memWe && nullFlag == (working_register
    == 8'h00) && working_register == $past(working_register ^ memRdata); endproperty
  a_xrg: assert property (p_xrg) else $error("register xor wrong");
  property p_xmm; hit[skip_table_xor_pkg::OP_XOR_MEM] |=> memWe && memWaddr == $past(memAddr)
    && memWdata == $past(working_register ^ memRdata) && nullFlag == (memWdata == 8'h00)
    && $stable(working_register); endproperty
  a_xmm: assert property (p_xmm) else $error("memory xor wrong");
  property p_ximm; hit[skip_table_xor_pkg::OP_XOR_IMM] |=> !memWe && nullFlag ==
    (working_register == 8'h00) && working_register == $past(working_register ^ literal);
  endproperty
  a_ximm: assert property (p_ximm) else $error("immediate xor wrong");
  c_skip: cover property (hit[skip_table_xor_pkg::OP_SKIPNULL] && discardPrefetch);
  c_tbl: cover property (hit[skip_table_xor_pkg::OP_TBL_LAST]);
  c_xmm: cover property (hit[skip_table_xor_pkg::OP_XOR_MEM] ##1 nullFlag);
endmodule // skip_table_xor_chk
bind skip_table_xor_exec skip_table_xor_chk skip_table_xor_chk_i (.*);

// >>> bench/mem_model.sv
// model: data memory and program memory beside the execution block
`timescale 1ns/1ps
module mem_model (
  input wire logic clk_sys, memWe, romRe,
  input wire logic [7:0] memAddr, memWaddr, memWdata,
  input wire logic [11:0] romAddr,
  output logic [7:0] memRdata,
  output logic [14:0] romData
);
  logic [7:0] mem [256];
  logic [14:0] word;
  assign memRdata = mem[memAddr];
  assign word = {3'h5, romAddr} ^ 15'h1234;
  // inverted outside the read cycle so a late sample never matches
  assign romData = romRe ? word : ~word;
  always @(posedge clk_sys) if (memWe) mem[memWaddr] <= memWdata;
endmodule // mem_model

// >>> bench/test_skip_table_xor_exec.sv
// testbench: directed runs of the skip/table/xor execution block
`timescale 1ns/1ps
module test_skip_table_xor_exec;
  logic clk_sys, rstn, opStart, busy, discardPrefetch, memWe, romRe, nullFlag, disc;
  skip_table_xor_pkg::op_e opValid;
  logic [2:0] bitSel;
  logic [3:0] curPage;
  logic [7:0] memAddr, memRdata, table_pointer, memWaddr, memWdata, working_register, literal;
  logic [6:0] table_high_latch;
  logic [11:0] romAddr;
  logic [14:0] romData, w;
  int miscompares, checked, n;
  skip_table_xor_exec skip_table_xor_exec_i (.*);
  mem_model mem_model_i (.*);
  task automatic chk(input string nm, input logic [14:0] got, input logic [14:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // n counts busy cycles over c0..c2; ends after any memory write has landed
  task automatic issue(input skip_table_xor_pkg::op_e op, input logic [7:0] m);
    @(posedge clk_sys);
    mem_model_i.mem[m ^ 8'hC3] <= m;
    opValid <= op;
    opStart <= 1'b1;
    memAddr <= m ^ 8'hC3;
    @(negedge clk_sys) disc = discardPrefetch;
    n = busy;
    @(posedge clk_sys) opStart <= 1'b0;
    repeat (2) @(negedge clk_sys) n += busy;
    @(negedge clk_sys);
  endtask
  task automatic t_skip;
    for (int i = 0; i < 2; i++) begin
      issue(skip_table_xor_pkg::OP_SKIPNULL, 8'(i));
      chk("null skip", {disc, n[1:0]}, {i == 0, i == 0 ? 2'h2 : 2'h0});
      issue(skip_table_xor_pkg::OP_COPYSKIP, 8'(i));
      chk("copy skip", {disc, n[1:0], working_register}, {i == 0, i == 0 ? 2'h2 : 2'h0, 8'(i)});
      issue(skip_table_xor_pkg::OP_BITSKIP, i == 0 ? 8'hF7 : 8'h08);
      chk("bit skip", {disc, n[1:0]}, {i == 0, i == 0 ? 2'h2 : 2'h0});
    end
    $display("skip test done");
  endtask
  task automatic t_xor;
    issue(skip_table_xor_pkg::OP_COPYSKIP, 8'h5C);
    issue(skip_table_xor_pkg::OP_XOR_REG, 8'h5C);
    chk("xor reg", {nullFlag, working_register}, {1'b1, 8'h00});
    issue(skip_table_xor_pkg::OP_XOR_IMM, 8'h01);
    chk("xor imm", {nullFlag, working_register}, {1'b0, 8'h3C});
    issue(skip_table_xor_pkg::OP_XOR_MEM, 8'h3C);
    chk("xor mem", {nullFlag, working_register, mem_model_i.mem[8'hFF]}, {1'b1, 8'h3C, 8'h00});
    $display("xor test done");
  endtask
  task automatic t_nib;
    issue(skip_table_xor_pkg::OP_NIBX, 8'hA5);
    chk("nibble", {nullFlag, n[1:0], working_register}, {1'b1, 2'h0, 8'h5A});
    chk("nibble mem", mem_model_i.mem[8'h66], 8'hA5);
    $display("nibble test done");
  endtask
  task automatic t_table(input skip_table_xor_pkg::op_e op, input logic [3:0] pg);
    w = {3'h5, pg, 8'h9A} ^ 15'h1234;
    issue(op, 8'h11);
    chk("table low", mem_model_i.mem[8'hD2], w[7:0]);
    chk("table high", {n[1:0], table_high_latch}, {2'h2, w[14:8]});
    $display("table test done");
  endtask
  // a start in the dummy cycle of a taken skip must be ignored
  task automatic t_refuse;
    @(posedge clk_sys);
    mem_model_i.mem[8'hC3] <= 8'h00;
    opValid <= skip_table_xor_pkg::OP_SKIPNULL;
    opStart <= 1'b1;
    memAddr <= 8'hC3;
    @(posedge clk_sys) opValid <= skip_table_xor_pkg::OP_XOR_IMM;
    @(posedge clk_sys) opStart <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("refused start", {nullFlag, working_register}, {1'b1, 8'h5A});
    $display("refuse test done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {rstn, opStart, miscompares, checked} = '0;
    opValid = skip_table_xor_pkg::OP_NONE;
    {memAddr, bitSel, literal, curPage, table_pointer} = {8'h00, 3'h3, 8'h3C, 4'h6, 8'h9A};
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t_skip;
    t_xor;
    t_nib;
    t_table(skip_table_xor_pkg::OP_TBL_CUR, 4'h6);
    t_table(skip_table_xor_pkg::OP_TBL_LAST, 4'hF);
    t_refuse;
    wrap_up;
  end
  // whole run is about 60 cycles
  initial begin
    #50000;
    miscompares++;
    wrap_up;
  end
endmodule // test_skip_table_xor_exec
